// ==== rtl/brn_pkg.sv ====
// brn_pkg: register map, field layout, reset values and error codes
// of the bus reset node status block.
// assumes: byte addressed 32-bit register bus, one word per register.
`default_nettype none

package brn_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] NODE_INFO_OFS  = 8'h48;
    localparam logic [7:0] ERR_STATUS_OFS = 8'h4C;

    ////////////////////////////////////////////////////////////////////////
    // node info field positions
    localparam int BUS_NUM_LSB  = 0;
    localparam int NODE_NUM_LSB = 10;
    localparam int VALID_BIT    = 16;
    localparam int NODE_CNT_LSB = 18;
    localparam int ROOT_BIT     = 24;
    localparam int IRM_LSB      = 25;

    // error status field positions
    localparam int CLR_BIT      = 0;
    localparam int ERR_LSB      = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [9:0] BUS_NUM_RST  = 10'h3FF;
    localparam logic [5:0] NODE_NUM_RST = 6'h3F;
    localparam logic [5:0] NODE_CNT_RST = 6'h01;
    localparam logic [5:0] IRM_RST      = 6'h3F;
    localparam logic [3:0] ERR_RST      = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // self-id error codes
    localparam logic [3:0] ERR_NONE       = 4'h0;
    localparam logic [3:0] ERR_LAST_CHILD = 4'h1;
    localparam logic [3:0] ERR_EXP_PHY    = 4'h2;
    localparam logic [3:0] ERR_NOT_INV    = 4'h3;
    localparam logic [3:0] ERR_INC_TWO    = 4'h4;
    localparam logic [3:0] ERR_INC_MORE   = 4'h5;
    localparam logic [3:0] ERR_PHY_PKT    = 4'h6;
    localparam logic [3:0] ERR_QUAD_INV   = 4'h7;
    localparam logic [3:0] ERR_BAD        = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // self-id quadlet layout
    localparam logic [1:0] SID_TAG     = 2'h2;
    localparam int         SID_TAG_LSB = 30;
    localparam int         SID_PHY_LSB = 24;
    localparam int         SID_EXT_BIT = 23;
    localparam int         SID_LNK_BIT = 22;
    localparam int         SID_CON_BIT = 11;
    localparam int         SID_MORE    = 0;
    localparam logic [1:0] PORT_PARENT = 2'h2;
    localparam int         PKT0_PORTS  = 3;
    localparam int         EXT_PORTS   = 8;

    typedef enum logic {
        SID_FIRST,
        SID_INVERSE
    } brn_sid_phase_t;

endpackage

`default_nettype wire

// ==== rtl/brn_node_status.sv ====
// brn_node_status: node identity, node count, root, resource manager id
// and self-id checking of a serial bus link, behind an avalon-mm slave.
// assumes: status and self-id inputs come from link logic on ref_clk;
// swReset is a one-cycle pulse from the device's own reset control.
//
// How it works
// - bus number bits 0-9, software writable, 3FF after power-up or soft reset.
// - node number bits 10-15, software writable, loaded from own self-id status.
// - node number forced to 3F on bus reset status, power-up, soft reset.
// - valid bit 16 set only when node count and manager id are valid.
// - node count bits 18-23, read only, 1 after any reset.
// - bit 24 shows whether the local phy is root.
// - manager id bits 25-31, read only, 3F after any reset.
// - all other fields of both registers clear on power-up or soft reset.
// - writing 1 to error bit 0 clears code to zero, or to the code of a fault seen that cycle; bit self clears.
// - error code bits 1-4, read only, zero means no error.
// - code 1 when last self-id has a port marked parent.
// - code 2 when self-id phy id is below the expected one.
// - code 3 when second quadlet of packet zero is not inverse.
// - code 4 when phy id advances by exactly two.
// - code 5 when phy id advances by three or more.
// - code 6 when phy id differs inside one self-id packet.
// - code 7 when extended self-id quadlets are not inverses.
// - code 8 for any otherwise malformed self-id quadlet.
//
// The Avalon-MM interface to the registers was decided locally.
`default_nettype none

module brn_node_status
    import brn_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        swReset,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output var  logic [31:0] readdata,
    output var  logic        waitrequest,
    // phy status responses
    input  wire logic        statusValid,
    input  wire logic        statusBusReset,
    input  wire logic        statusOwnSelfId,
    input  wire logic [5:0]  statusNodeId,
    input  wire logic        statusRoot,
    // received self-id quadlets
    input  wire logic        selfIdValid,
    input  wire logic [31:0] selfIdQuad,
    input  wire logic        selfIdEnd,
    // node identity for the rest of the link
    output var  logic [9:0]  busNumber,
    output var  logic [5:0]  localNodeNumber
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic hitReg(input logic [7:0] a,
                                    input logic [7:0] ofs);
        hitReg = (a == ofs);
    endfunction

    function automatic logic hasParent(input logic [31:0] q,
                                       input logic        ext);
        logic found;
        found = 1'b0;
        for (int i = 0; i < EXT_PORTS; i++) begin
            if ((ext || i < PKT0_PORTS) &&
                q[2*i+3 -: 2] == PORT_PARENT) begin
                found = 1'b1;
            end
        end
        hasParent = found;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic            waitReq_q;
    logic [31:0]     readData_q;
    logic [9:0]      bus_number_q;
    logic [5:0]      local_node_number_q;
    logic            valid_q;
    logic [5:0]      node_count_q;
    logic            root_q;
    logic [5:0]      irm_q;
    logic [3:0]      errCode_q;
    logic [3:0]      errDet;
    brn_sid_phase_t  phase_q;
    logic [31:0]     firstQuad_q;
    logic [5:0]      expPhy_q;
    logic [5:0]      pktPhy_q;
    logic            inPacket_q;
    logic            lastParent_q;
    logic [5:0]      irmCand_q;
    logic            irmFound_q;

    logic            accept;
    logic            wrNode;
    logic            wrErr;
    logic            busReset;
    logic [5:0]      sidPhy;
    logic [5:0]      phyDiff;
    logic            sidExt;
    logic            stepTwo;
    logic            stepMore;
    logic            clrErr;

    assign accept   = (read || write) && !waitReq_q;
    assign wrNode   = accept && write && hitReg(address, NODE_INFO_OFS);
    assign wrErr    = accept && write && hitReg(address, ERR_STATUS_OFS);
    assign busReset = statusValid && statusBusReset;
    assign sidPhy   = selfIdQuad[SID_PHY_LSB +: 6];
    assign phyDiff  = sidPhy - expPhy_q;
    assign sidExt   = selfIdQuad[SID_EXT_BIT];
    assign clrErr   = wrErr && byteenable[0] && writedata[CLR_BIT];
    // expected id is last plus one: a step of two is one past it
    assign stepTwo  = (sidPhy > expPhy_q) && (phyDiff == 6'h01);
    assign stepMore = (sidPhy > expPhy_q) && (phyDiff > 6'h01);

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then answer for one cycle

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            waitReq_q <= 1'b1;
        end else begin
            waitReq_q <= !((read || write) && waitReq_q);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            readData_q <= 32'h0000_0000;
        end else if ((read || write) && waitReq_q) begin
            if (read && hitReg(address, NODE_INFO_OFS)) begin
                readData_q <= 32'h0000_0000;
                readData_q[BUS_NUM_LSB +: 10] <= bus_number_q;
                readData_q[NODE_NUM_LSB +: 6] <= local_node_number_q;
                readData_q[VALID_BIT]         <= valid_q;
                readData_q[NODE_CNT_LSB +: 6] <= node_count_q;
                readData_q[ROOT_BIT]          <= root_q;
                // manager id is six bits, the field's top bit reads zero
                readData_q[IRM_LSB +: 7]      <= {1'b0, irm_q};
            end else if (read && hitReg(address, ERR_STATUS_OFS)) begin
                readData_q <= 32'h0000_0000;
                readData_q[ERR_LSB +: 4] <= errCode_q;
            end else begin
                readData_q <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus number

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_number_q <= BUS_NUM_RST;
        end else if (swReset) begin
            bus_number_q <= BUS_NUM_RST;
        end else if (wrNode) begin
            if (byteenable[0]) begin
                bus_number_q[7:0] <= writedata[7:0];
            end
            if (byteenable[1]) begin
                bus_number_q[9:8] <= writedata[9:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // local node number: reset beats phy load beats software

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            local_node_number_q <= NODE_NUM_RST;
        end else if (swReset || busReset) begin
            local_node_number_q <= NODE_NUM_RST;
        end else if (statusValid && statusOwnSelfId) begin
            local_node_number_q <= statusNodeId;
        end else if (wrNode && byteenable[1]) begin
            local_node_number_q <= writedata[NODE_NUM_LSB +: 6];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // root state

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            root_q <= 1'b0;
        end else if (swReset) begin
            root_q <= 1'b0;
        end else if (statusValid) begin
            root_q <= statusRoot;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // node count, manager id, valid

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            node_count_q <= NODE_CNT_RST;
            irm_q     <= IRM_RST;
            valid_q   <= 1'b0;
        end else if (swReset || busReset) begin
            node_count_q <= NODE_CNT_RST;
            irm_q     <= IRM_RST;
            valid_q   <= 1'b0;
        end else if (selfIdEnd) begin
            // count is the last packet-zero id plus one
            node_count_q <= expPhy_q;
            irm_q     <= irmFound_q ? irmCand_q : IRM_RST;
            valid_q   <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-id checking, first fault of this cycle

    always_comb begin
        errDet = ERR_NONE;
        if (selfIdValid && phase_q == SID_FIRST) begin
            if (selfIdQuad[SID_TAG_LSB +: 2] != SID_TAG) begin
                errDet = ERR_BAD;
            end else if (inPacket_q) begin
                if (!sidExt) begin
                    errDet = ERR_BAD;
                end else if (sidPhy != pktPhy_q) begin
                    errDet = ERR_PHY_PKT;
                end
            end else if (sidExt) begin
                errDet = ERR_BAD;
            end else if (stepTwo) begin
                errDet = ERR_INC_TWO;
            end else if (stepMore) begin
                errDet = ERR_INC_MORE;
            end else if (sidPhy != expPhy_q) begin
                errDet = ERR_EXP_PHY;
            end
        end else if (selfIdValid && phase_q == SID_INVERSE) begin
            if (selfIdQuad != ~firstQuad_q) begin
                if (!firstQuad_q[SID_EXT_BIT]) begin
                    errDet = ERR_NOT_INV;
                end else begin
                    errDet = ERR_QUAD_INV;
                end
            end
        end else if (selfIdEnd) begin
            if (phase_q == SID_INVERSE || inPacket_q) begin
                errDet = ERR_BAD;
            end else if (lastParent_q) begin
                errDet = ERR_LAST_CHILD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-id tracking

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_q      <= SID_FIRST;
            firstQuad_q  <= 32'h0000_0000;
            expPhy_q     <= 6'h00;
            pktPhy_q     <= 6'h00;
            inPacket_q   <= 1'b0;
            lastParent_q <= 1'b0;
            irmCand_q    <= 6'h00;
            irmFound_q   <= 1'b0;
        end else if (swReset || busReset) begin
            phase_q      <= SID_FIRST;
            firstQuad_q  <= 32'h0000_0000;
            expPhy_q     <= 6'h00;
            pktPhy_q     <= 6'h00;
            inPacket_q   <= 1'b0;
            lastParent_q <= 1'b0;
            irmCand_q    <= 6'h00;
            irmFound_q   <= 1'b0;
        end else if (selfIdValid) begin
            case (phase_q)
                SID_FIRST: begin
                    firstQuad_q <= selfIdQuad;
                    phase_q     <= SID_INVERSE;
                end
                SID_INVERSE: begin
                    phase_q    <= SID_FIRST;
                    inPacket_q <= firstQuad_q[SID_MORE];
                    // packet zero sets the next id; extended ones add ports
                    if (!firstQuad_q[SID_EXT_BIT]) begin
                        pktPhy_q     <= firstQuad_q[SID_PHY_LSB +: 6];
                        expPhy_q     <= firstQuad_q[SID_PHY_LSB +: 6]
                                        + 6'h01;
                        lastParent_q <= hasParent(firstQuad_q, 1'b0);
                        if (firstQuad_q[SID_CON_BIT] &&
                            firstQuad_q[SID_LNK_BIT]) begin
                            irmCand_q  <= firstQuad_q[SID_PHY_LSB +: 6];
                            irmFound_q <= 1'b1;
                        end
                    end else if (hasParent(firstQuad_q, 1'b1)) begin
                        lastParent_q <= 1'b1;
                    end
                end
                default: begin
                    phase_q <= SID_FIRST;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error code: first fault held, a new fault wins over a clear

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            errCode_q <= ERR_RST;
        end else if (swReset) begin
            errCode_q <= ERR_RST;
        end else if (errCode_q == ERR_NONE && errDet != ERR_NONE) begin
            errCode_q <= errDet;
        end else if (clrErr) begin
            // a fault in the clear's own cycle is loaded, none is lost
            errCode_q <= errDet;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign readdata        = readData_q;
    assign waitrequest     = waitReq_q;
    assign busNumber       = bus_number_q;
    assign localNodeNumber = local_node_number_q;

endmodule // brn_node_status

`default_nettype wire

// ==== tb/brn_node_status_chk.sv ====
// brn_node_status_chk: port assertions for brn_node_status
// assumes: bound into the design, one clock ref_clk, async rst
`default_nettype none
module brn_node_status_chk
    import brn_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        swReset,
    // register bus
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // status and identity
    input wire logic        statusValid,
    input wire logic        statusBusReset,
    input wire logic        statusOwnSelfId,
    input wire logic [5:0]  statusNodeId,
    input wire logic [9:0]  busNumber,
    input wire logic [5:0]  localNodeNumber
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    sequence req_s; (read || write) && waitrequest; endsequence
    sequence ack_s; !waitrequest ##1 waitrequest; endsequence
    sequence rd_s(sel); read && !waitrequest && sel; endsequence
    ////////////////////////////////////////////////////////////////////////
    wait_one_a: assert property (req_s |=> ack_s)
        else $error("waitrequest not low for one cycle");
    wait_idle_a: assert property (!(read || write) |=> waitrequest)
        else $error("waitrequest low without request");
    sw_bus_a: assert property (swReset |=> busNumber == BUS_NUM_RST)
        else $error("bus number not reset");
    node_rst_a: assert property ((swReset || statusValid && statusBusReset)
        |=> localNodeNumber == NODE_NUM_RST) else $error("node not forced");
    node_own_a: assert property (statusValid && statusOwnSelfId
        && !statusBusReset && !swReset |=> localNodeNumber ==
        $past(statusNodeId)) else $error("node number not loaded");
    bus_hold_a: assert property (!swReset && !(write && !waitrequest
        && address == NODE_INFO_OFS) |=> $stable(busNumber))
        else $error("bus number changed");
    info_zero_a: assert property (rd_s(address == NODE_INFO_OFS)
        |-> readdata[17] == 1'b0 && readdata[31] == 1'b0)
        else $error("unused node info bit set");
    err_zero_a: assert property (rd_s(address == ERR_STATUS_OFS)
        |-> readdata[0] == 1'b0 && readdata[31:5] == 27'h0)
        else $error("error register spare bits set");
    unmap_a: assert property (rd_s(address != NODE_INFO_OFS
        && address != ERR_STATUS_OFS) |-> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule // brn_node_status_chk

bind brn_node_status brn_node_status_chk chk (.ref_clk(ref_clk), .rst(rst),
    .swReset(swReset), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest),
    .statusValid(statusValid), .statusBusReset(statusBusReset),
    .statusOwnSelfId(statusOwnSelfId), .statusNodeId(statusNodeId),
    .busNumber(busNumber), .localNodeNumber(localNodeNumber));
`default_nettype wire

// ==== tb/brn_phy_model.sv ====
// brn_phy_model: phy side, status responses and self-id quadlets
// assumes: tasks called from the bench, all outputs on ref_clk
`default_nettype none
module brn_phy_model (
    // clock
    input  wire logic        ref_clk,
    // status responses
    output var  logic        statusValid,
    output var  logic        statusBusReset,
    output var  logic        statusOwnSelfId,
    output var  logic [5:0]  statusNodeId,
    output var  logic        statusRoot,
    // self-id quadlets
    output var  logic        selfIdValid,
    output var  logic [31:0] selfIdQuad,
    output var  logic        selfIdEnd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {statusValid, statusBusReset, statusOwnSelfId, statusRoot} = 4'h0;
        {selfIdValid, selfIdEnd} = 2'b00;
        statusNodeId = 6'h00;
        selfIdQuad = 32'h0000_0000;
    end
    // one status response; released id field shows the inverse
    task automatic status(input logic br, input logic own,
                          input logic [5:0] id, input logic rt);
        @(posedge ref_clk);
        statusValid <= 1'b1;
        statusBusReset <= br;
        statusOwnSelfId <= own;
        statusNodeId <= id;
        statusRoot <= rt;
        @(posedge ref_clk);
        statusValid <= 1'b0;
        statusNodeId <= ~id;
    endtask
    task automatic quad(input logic [31:0] q);
        @(posedge ref_clk);
        selfIdValid <= 1'b1;
        selfIdQuad <= q;
        @(posedge ref_clk);
        selfIdValid <= 1'b0;
        selfIdQuad <= ~q;
    endtask
    // data quadlet then its inverse, mask spoils the inverse
    task automatic pkt(input logic [31:0] q, input logic [31:0] m);
        quad(q);
        quad(~q ^ m);
    endtask
    task automatic fin();
        @(posedge ref_clk);
        selfIdEnd <= 1'b1;
        @(posedge ref_clk);
        selfIdEnd <= 1'b0;
    endtask
endmodule // brn_phy_model
`default_nettype wire

// ==== tb/brn_node_status_tb.sv ====
// brn_node_status_tb: self-checking bench for brn_node_status
// assumes: brn_phy_model drives the phy side, checker bound in
`default_nettype none
module brn_node_status_tb
    import brn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst, swReset, read, write, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata, selfIdQuad;
    logic [3:0] byteenable;
    logic statusValid, statusBusReset, statusOwnSelfId, statusRoot;
    logic selfIdValid, selfIdEnd;
    logic [5:0] statusNodeId, localNodeNumber;
    logic [9:0] busNumber;
    int errTotal, samplesChecked;
    brn_node_status dut (.ref_clk(ref_clk), .rst(rst), .swReset(swReset),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .statusValid(statusValid), .statusBusReset(statusBusReset),
        .statusOwnSelfId(statusOwnSelfId), .statusNodeId(statusNodeId),
        .statusRoot(statusRoot), .selfIdValid(selfIdValid),
        .selfIdQuad(selfIdQuad), .selfIdEnd(selfIdEnd),
        .busNumber(busNumber), .localNodeNumber(localNodeNumber));
    brn_phy_model phy (.ref_clk(ref_clk), .statusValid(statusValid),
        .statusBusReset(statusBusReset), .statusOwnSelfId(statusOwnSelfId),
        .statusNodeId(statusNodeId), .statusRoot(statusRoot),
        .selfIdValid(selfIdValid), .selfIdQuad(selfIdQuad),
        .selfIdEnd(selfIdEnd));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (errTotal == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        samplesChecked++;
        if (q !== e) begin
            errTotal++;
            $display("[FAIL] %0t reg %h got %h exp %h", $time, a, q, e);
        end
    endtask
    function automatic logic [31:0] info(logic [6:0] irm, logic [5:0] cnt,
        int rt, int vld, logic [5:0] node, logic [9:0] bus);
        return {irm, rt[0], cnt, 1'b0, vld[0], node, bus};
    endfunction
    function automatic logic [31:0] p0(int p);
        return {2'b10, p[5:0], 24'h00_00FC};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(8'h48, info(7'h3F, 6'h01, 0, 0, 6'h3F, 10'h3FF));
        chk(8'h4C, 32'h0000_0000);
        chk(8'h50, 32'h0000_0000);
    endtask
    task automatic t_write();
        wr(8'h48, 32'hFFFF_A5A5);
        chk(8'h48, info(7'h3F, 6'h01, 0, 0, 6'h29, 10'h1A5));
        byteenable <= 4'h1;
        wr(8'h48, 32'hFFFF_FFA5);
        byteenable <= 4'hF;
        chk(8'h48, info(7'h3F, 6'h01, 0, 0, 6'h29, 10'h1A5));
        wr(8'h50, 32'hFFFF_FFFF);
        chk(8'h4C, 32'h0000_0000);
    endtask
    task automatic t_status();
        phy.status(1'b0, 1'b1, 6'h05, 1'b1);
        chk(8'h48, info(7'h3F, 6'h01, 1, 0, 6'h05, 10'h1A5));
        phy.status(1'b1, 1'b0, 6'h07, 1'b1);
        chk(8'h48, info(7'h3F, 6'h01, 1, 0, 6'h3F, 10'h1A5));
    endtask
    task automatic t_good();
        phy.pkt(p0(6'd0), 32'h0);
        phy.pkt(p0(6'd1) | 32'h0040_0800, 32'h0);
        phy.pkt(p0(6'd2), 32'h0);
        phy.fin();
        chk(8'h48, info(7'h01, 6'h03, 1, 1, 6'h3F, 10'h1A5));
        chk(8'h4C, 32'h0000_0000);
        phy.status(1'b1, 1'b0, 6'h3F, 1'b1);
        chk(8'h48, info(7'h3F, 6'h01, 1, 0, 6'h3F, 10'h1A5));
    endtask
    task automatic err_case(input logic [3:0] code, input logic [31:0] qa,
        input logic [31:0] ma, input logic [31:0] qb, input logic [31:0] mb,
        input int two);
        phy.status(1'b1, 1'b0, 6'h3F, 1'b1);
        phy.pkt(qa, ma);
        if (two) phy.pkt(qb, mb);
        phy.fin();
        chk(8'h4C, {27'h0, code, 1'b0});
        phy.quad(32'h4000_0000);
        chk(8'h4C, {27'h0, code, 1'b0});
        wr(8'h4C, 32'h0000_0001);
        chk(8'h4C, 32'h0000_0000);
    endtask
    task automatic t_errors();
        err_case(4'h1, 32'h8000_00BC, 0, 0, 0, 0);
        err_case(4'h2, p0(0), 0, p0(0), 0, 1);
        err_case(4'h3, p0(0), 32'h1, 0, 0, 0);
        err_case(4'h4, p0(0), 0, p0(2), 0, 1);
        err_case(4'h5, p0(0), 0, p0(3), 0, 1);
        err_case(4'h6, p0(0) | 1, 0, 32'h81BF_FFFC, 0, 1);
        err_case(4'h7, p0(0) | 1, 0, 32'h80BF_FFFC, 32'h1, 1);
        err_case(4'h8, 32'h4000_00FC, 0, 0, 0, 0);
    endtask
    task automatic t_swreset();
        phy.quad(32'h4000_0000);
        chk(8'h4C, 32'h0000_0006);
        @(posedge ref_clk);
        swReset <= 1'b1;
        @(posedge ref_clk);
        swReset <= 1'b0;
        chk(8'h48, info(7'h3F, 6'h01, 0, 0, 6'h3F, 10'h3FF));
        chk(8'h4C, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errTotal++;
        close_out();
    end
    initial begin
        {rst, swReset, read, write} = 4'b1000;
        address = 8'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        errTotal = 0;
        samplesChecked = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_write();
        t_status();
        t_good();
        t_errors();
        t_swreset();
        close_out();
    end
endmodule // brn_node_status_tb
`default_nettype wire
